// ==== core/fvb_params.svh ====
// Operation
// - lengthen on-time when negative clamp below 80%
// - zero-cross extension gain from pre-start resistance
// - accept 68k weak, feedback on at or above 27k
// - 210uA max power, 610uA min power
// - line sync only with detectable ripple
// - run in valley mode or burst mode
// - valley turn-on controlling on-time and valley
// - compensate on-time on valley number change
// - valley rises as power falls, max 32
// - off-time limited to 47us
// - sleep in burst pause until wake event
// - reduced 7V gate level through burst mode
// - wake at four times line, sample, pulse
// - no sync before burst gives 200Hz wake
// - supply 7.6V starts burst until 8.1V
// - supply wake level disables config pull-up
// - skips lengthen, supply wakes shorten burst cycle
// - map feedback to pulse, valley, burst duty
// - weak winding restarts 52us after turn-off
// - 560uA is valley/burst boundary
// - skip burst pulsing at or above 610uA
`ifndef FVB_PARAMS_SVH
`define FVB_PARAMS_SVH
// ====================================================
// register map (byte addresses)
`define FVB_OFS_CTRL 8'h00
`define FVB_OFS_STATUS 8'h04
`define FVB_OFS_VALLEY 8'h08
`define FVB_OFS_TON 8'h0C
`define FVB_OFS_CFG 8'h10
`define FVB_CTRL_RUN 0
`define FVB_CTRL_BURST 1
`define FVB_CTRL_RESET 2'h2
// ====================================================
// thresholds
`define FVB_FB_MAXP_UA 10'd210
`define FVB_FB_MINP_UA 10'd610
`define FVB_FB_BURST_UA 10'd560
`define FVB_FB_HALVE_UA 10'd50
`define FVB_VALLEY_STEP_UA 10'd11
`define FVB_VALLEY_MAX 6'd32
`define FVB_VALLEY_JUMP 6'd10
`define FVB_CLAMP_PCT 80
`define FVB_RES_MIN_KOHM 8'd27
`define FVB_RES_MAX_KOHM 8'd68
`define FVB_DUTY_SHIFT 6
// ====================================================
// timing
`define FVB_CLK_MHZ 250
`define FVB_TOFF_NS 47000
`define FVB_TREP_NS 52000
`define FVB_WAKE_DEF_NS 5000000
`define FVB_TON_MAX_NS 20000
`define FVB_SYNC_LOST_US 25000
`define FVB_TOFF_CYC (`FVB_TOFF_NS * `FVB_CLK_MHZ / 1000)
`define FVB_TREP_CYC ((`FVB_TREP_NS * `FVB_CLK_MHZ + 999) / 1000)
`define FVB_WAKE_DEF_CYC (`FVB_WAKE_DEF_NS / 1000 * `FVB_CLK_MHZ)
`define FVB_TON_MAX_CYC (`FVB_TON_MAX_NS * `FVB_CLK_MHZ / 1000)
`define FVB_SYNC_LOST_CYC (`FVB_SYNC_LOST_US * `FVB_CLK_MHZ)
`endif

// ==== core/fvb_pkg.sv ====
package fvb_pkg;
  typedef enum logic [2:0] {ST_STOP, ST_ON, ST_OFF, ST_SLEEP} fvb_state_t;
endpackage

// ==== core/fvb_core.sv ====
`timescale 1ns/1ps
`include "fvb_params.svh"
module fvb_core #(
  parameter int TOFF_CYC = `FVB_TOFF_CYC,
  parameter int TREP_CYC = `FVB_TREP_CYC,
  parameter int WAKE_DEF_CYC = `FVB_WAKE_DEF_CYC,
  parameter int TON_MAX_CYC = `FVB_TON_MAX_CYC,
  parameter int SYNC_LOST_CYC = `FVB_SYNC_LOST_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic zero_cross_pin,
  input wire logic supply_wake_pin,
  input wire logic supply_stop_pin,
  input wire logic fb_valid,
  input wire logic [9:0] fb_ua,
  input wire logic [9:0] pos_clamp_current,
  input wire logic [9:0] neg_clamp_current,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_strong_kohm,
  input wire logic [7:0] cfg_weak_kohm,
  input wire logic line_tick,
  input wire logic ripple_ok,
  output logic gate_on,
  output logic gate_reduced,
  output logic pullup_on,
  output logic sleep
);
  import fvb_pkg::*;

  // ====================================================
  // pin synchronisers
  logic [2:0] pin_in;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  assign pin_in = {supply_stop_pin, supply_wake_pin, zero_cross_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate
  logic zc_edge;
  logic sup_wake_edge;
  logic sup_high;
  assign zc_edge = sync2_r[0] & ~sync3_r[0];
  assign sup_wake_edge = sync2_r[1] & ~sync3_r[1];
  assign sup_high = sync2_r[2];

  // ====================================================
  // register bus
  logic ack_r;
  logic [1:0] ctrl_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_mux;
  fvb_state_t st_r;
  logic burst_r;
  logic synced_r;
  logic fb_en_r;
  logic [6:0] gain_r;
  logic [5:0] valley_q_r;
  logic [17:0] ton_cyc_r;
  assign waitrequest = (read | write) & ~ack_r;
  assign readdata = readdata_r;
  always_comb
  begin
    unique case (address)
      `FVB_OFS_CTRL: rd_mux = {30'h0, ctrl_r};
      `FVB_OFS_STATUS: rd_mux = {26'h0, pullup_on, synced_r, fb_en_r,
        gate_reduced, sleep, burst_r};
      `FVB_OFS_VALLEY: rd_mux = {26'h0, valley_q_r};
      `FVB_OFS_TON: rd_mux = {14'h0, ton_cyc_r};
      `FVB_OFS_CFG: rd_mux = {25'h0, gain_r};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0;
      ctrl_r <= `FVB_CTRL_RESET;
    end
    else
    begin
      // one wait state on every access
      ack_r <= (read | write) & ~ack_r;
      if (read & ~ack_r)
        readdata_r <= rd_mux;
      if (write & ack_r & (address == `FVB_OFS_CTRL))
        ctrl_r <= writedata[1:0];
    end
  end

  // ====================================================
  // configuration captured before running
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fb_en_r <= 1'b0;
      gain_r <= 7'h0;
    end
    else if (cfg_valid & (st_r == ST_STOP))
    begin
      fb_en_r <= cfg_strong_kohm >= `FVB_RES_MIN_KOHM;
      // gain held until the next stopped capture
      gain_r <= (cfg_weak_kohm > `FVB_RES_MAX_KOHM) ?
        7'(`FVB_RES_MAX_KOHM) : cfg_weak_kohm[6:0];
    end
  end

  // ====================================================
  // feedback mapping
  logic [9:0] fb_r;
  logic [9:0] fbc;
  logic [9:0] fb_off;
  logic [3:0] halv;
  logic [15:0] ton_base;
  logic [5:0] valley_map;
  logic [21:0] comp_prod;
  logic [22:0] thd_prod;
  logic thd_zone;
  logic [9:0] duty;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fb_r <= `FVB_FB_MINP_UA;
    else if (fb_valid)
      fb_r <= fb_ua;
  end
  always_comb
  begin
    fbc = fb_r;
    if (fb_r < `FVB_FB_MAXP_UA)
      fbc = `FVB_FB_MAXP_UA;
    if (fb_r > `FVB_FB_MINP_UA)
      fbc = `FVB_FB_MINP_UA;
    fb_off = fbc - `FVB_FB_MAXP_UA;
    // pulse length halves every 50 uA above max-power point
    halv = 4'(fb_off / `FVB_FB_HALVE_UA);
    ton_base = 16'(TON_MAX_CYC) >> halv;
    valley_map = (fbc >= `FVB_FB_BURST_UA) ? `FVB_VALLEY_MAX :
      6'(fb_off / `FVB_VALLEY_STEP_UA) + 6'h1;
    if (valley_map > `FVB_VALLEY_MAX)
      valley_map = `FVB_VALLEY_MAX;
    duty = `FVB_FB_MINP_UA - fbc;
    comp_prod = ton_base * (valley_q_r - 6'h1);
    thd_prod = ton_base * gain_r;
    thd_zone = (32'(neg_clamp_current) * 100) <
      (32'(pos_clamp_current) * `FVB_CLAMP_PCT);
  end
  // on-time grows with valley so power holds across a valley step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ton_cyc_r <= 18'h1;
    else
      ton_cyc_r <= 18'(ton_base) + 18'(comp_prod >> 5)
        + (thd_zone ? 18'(thd_prod >> 6) : 18'h0);
  end

  // ====================================================
  // line synchronisation
  logic [23:0] half_cnt_r;
  logic [23:0] half_per_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      half_cnt_r <= 24'h0;
      half_per_r <= 24'h0;
      synced_r <= 1'b0;
    end
    else if (line_tick & ripple_ok & ~burst_r & (st_r != ST_STOP))
    begin
      half_per_r <= half_cnt_r;
      half_cnt_r <= 24'h0;
      synced_r <= 1'b1;
    end
    else if (half_cnt_r >= 24'(SYNC_LOST_CYC))
      synced_r <= 1'b0;
    else
      half_cnt_r <= half_cnt_r + 24'h1;
  end

  // ====================================================
  // valley selection with half-cycle hysteresis
  logic [5:0] vmin_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valley_q_r <= 6'h1;
      vmin_r <= `FVB_VALLEY_MAX;
    end
    else if (burst_r)
      valley_q_r <= valley_map;
    else if (line_tick | ~synced_r)
    begin
      valley_q_r <= (valley_map < vmin_r) ? valley_map : vmin_r;
      vmin_r <= `FVB_VALLEY_MAX;
    end
    else
    begin
      if (valley_map < vmin_r)
        vmin_r <= valley_map;
      if ((valley_map < valley_q_r) |
          (valley_map >= valley_q_r + `FVB_VALLEY_JUMP))
        valley_q_r <= valley_map;
    end
  end

  // ====================================================
  // wake timer
  logic [23:0] wake_per_r;
  logic [23:0] wcnt_r;
  logic tmr_wake;
  logic wake_evt;
  assign tmr_wake = burst_r & (wcnt_r >= wake_per_r - 24'h1);
  assign wake_evt = tmr_wake | (burst_r & sup_wake_edge);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wcnt_r <= 24'h0;
    else if (wake_evt | ~burst_r)
      wcnt_r <= 24'h0;
    else
      wcnt_r <= wcnt_r + 24'h1;
  end

  // ====================================================
  // pulse sequencer
  logic run_ok;
  logic [23:0] tcnt_r;
  logic [5:0] zc_n_r;
  logic zc_seen_r;
  logic [23:0] bwin_r;
  logic sup_burst_r;
  logic release_on;
  logic [33:0] blen;
  assign run_ok = ctrl_r[`FVB_CTRL_RUN] & fb_en_r;
  assign blen = 34'(wake_per_r >> `FVB_DUTY_SHIFT) * duty;
  assign release_on = (zc_n_r >= valley_q_r) |
    (zc_seen_r & (tcnt_r >= 24'(TOFF_CYC))) |
    (~zc_seen_r & (tcnt_r >= 24'(TREP_CYC)));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_STOP;
      gate_on <= 1'b0;
      tcnt_r <= 24'h0;
      zc_n_r <= 6'h0;
      zc_seen_r <= 1'b0;
      burst_r <= 1'b0;
      bwin_r <= 24'h0;
      sup_burst_r <= 1'b0;
      wake_per_r <= 24'(WAKE_DEF_CYC);
    end
    else if (~run_ok)
    begin
      st_r <= ST_STOP;
      gate_on <= 1'b0;
      burst_r <= 1'b0;
    end
    else
    begin
      tcnt_r <= tcnt_r + 24'h1;
      if (bwin_r != 24'h0)
        bwin_r <= bwin_r - 24'h1;
      if (burst_r & sup_wake_edge)
        sup_burst_r <= 1'b1;
      else if (sup_high)
        sup_burst_r <= 1'b0;
      unique case (st_r)
        ST_STOP:
        begin
          st_r <= ST_ON;
          gate_on <= 1'b1;
          tcnt_r <= 24'h0;
        end
        ST_ON:
          if (tcnt_r >= 24'(ton_cyc_r))
          begin
            st_r <= ST_OFF;
            gate_on <= 1'b0;
            tcnt_r <= 24'h0;
            zc_n_r <= 6'h0;
            zc_seen_r <= 1'b0;
          end
        ST_OFF:
        begin
          if (zc_edge)
          begin
            zc_n_r <= zc_n_r + 6'h1;
            zc_seen_r <= 1'b1;
          end
          // window over with the gate already low: sleep without a release
          if (burst_r & (bwin_r == 24'h0) & ~sup_burst_r)
            st_r <= ST_SLEEP;
          else if (release_on)
          begin
            tcnt_r <= 24'h0;
            if (~burst_r & ctrl_r[`FVB_CTRL_BURST] &
                (fb_r >= `FVB_FB_BURST_UA))
            begin
              burst_r <= 1'b1;
              // last synced line: wake at four per line period
              wake_per_r <= synced_r ? (half_per_r >> 1) :
                24'(WAKE_DEF_CYC);
              st_r <= ST_SLEEP;
            end
            else
            begin
              st_r <= ST_ON;
              gate_on <= 1'b1;
            end
          end
        end
        ST_SLEEP:
          if (wake_evt | sup_burst_r)
          begin
            if ((fb_r < `FVB_FB_BURST_UA) & ~sup_burst_r)
              burst_r <= 1'b0;
            if ((fb_r >= `FVB_FB_MINP_UA) & ~sup_burst_r & ~sup_wake_edge)
              st_r <= ST_SLEEP;
            else
            begin
              bwin_r <= (blen > 34'hFFFFFF) ? 24'hFFFFFF : blen[23:0];
              st_r <= ST_ON;
              gate_on <= 1'b1;
              tcnt_r <= 24'h0;
            end
          end
        default:
          st_r <= ST_STOP;
      endcase
    end
  end

  // ====================================================
  // supply-side outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pullup_on <= 1'b1;
      gate_reduced <= 1'b0;
      sleep <= 1'b0;
    end
    else
    begin
      gate_reduced <= burst_r;
      sleep <= (st_r == ST_SLEEP);
      if (burst_r & sup_wake_edge)
        pullup_on <= 1'b0;
      else if (sup_high | ~burst_r)
        pullup_on <= 1'b1;
    end
  end

  // ====================================================
  // checks
  a_gate_sleep_low: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_SLEEP) |-> !gate_on)
    else $error("gate high while asleep");
  a_gate_reduced: assert property (@(posedge clk) disable iff (rst)
    $rose(burst_r) |=> gate_reduced)
    else $error("reduced gate level missing");
  a_valley_range: assert property (@(posedge clk) disable iff (rst)
    (valley_q_r >= 6'h1) && (valley_q_r <= `FVB_VALLEY_MAX))
    else $error("valley out of range");
  a_off_bound: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_OFF) |-> tcnt_r <= 24'(TREP_CYC))
    else $error("off time overran");
  a_pullup_drop: assert property (@(posedge clk) disable iff (rst)
    (run_ok && burst_r && sup_wake_edge) |=> !pullup_on)
    else $error("pull-up kept at wake level");
  a_max_power: assert property (@(posedge clk) disable iff (rst)
    (fb_r <= `FVB_FB_MAXP_UA) |-> ton_base == 16'(TON_MAX_CYC))
    else $error("max power not commanded");
  a_burst_skip: assert property (@(posedge clk) disable iff (rst)
    (run_ok && st_r == ST_SLEEP && tmr_wake && !sup_burst_r &&
     !sup_wake_edge && fb_r >= `FVB_FB_MINP_UA)
    |=> (st_r == ST_SLEEP) && !gate_on)
    else $error("burst not skipped");
  a_fb_disabled: assert property (@(posedge clk) disable iff (rst)
    !fb_en_r |=> !gate_on && st_r == ST_STOP)
    else $error("pulsing without feedback");
  a_bus_wait: assert property (@(posedge clk) disable iff (rst)
    ((read || write) && !ack_r) |-> waitrequest ##1 !waitrequest)
    else $error("bus wait state wrong");
endmodule // fvb_core

// ==== test/fvb_winding_model.sv ====
`timescale 1ns/1ps
module fvb_winding_model #(
  parameter int RING_CYC = 6
) (
  input wire logic clk,
  input wire logic gate_on,
  input wire logic ring_en,
  output logic zero_cross_pin
);
  int cnt;
  // ==========================================
  // ringing after turn-off
  // a weak winding (ring_en low) gives no crossings at all
  initial zero_cross_pin = 1'b0;
  always @(posedge clk)
  begin
    if (gate_on !== 1'b0 || !ring_en)
    begin
      cnt <= 0;
      zero_cross_pin <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == RING_CYC - 1) ? 0 : cnt + 1;
      zero_cross_pin <= (cnt < RING_CYC / 2);
    end
  end
endmodule // fvb_winding_model

// ==== test/fvb_core_tb.sv ====
`timescale 1ns/1ps
module fvb_core_tb;
  import fvb_pkg::*;
  localparam int TOFF = 40;
  localparam int TREP = 50;
  logic clk, rst, read, write, fb_valid, cfg_valid, gate_q;
  logic line_tick, ripple_ok, ring_en, line_en, zero_cross_pin;
  logic supply_wake_pin, supply_stop_pin;
  logic [7:0] address, cfg_strong_kohm, cfg_weak_kohm;
  logic [31:0] writedata, readdata, q, t0;
  logic [9:0] fb_ua, pos_clamp_current, neg_clamp_current;
  logic waitrequest, gate_on, gate_reduced, pullup_on, sleep;
  int bad_count, n_tests, t, b, d, r0, rises, lk;
  logic [9:0] fbs [4] = '{10'h226, 10'h0DD, 10'h0D2, 10'h258};
  logic [31:0] vls [4] = '{32'h1F, 32'h2, 32'h1, 32'h20};

  fvb_core #(
    .TOFF_CYC(TOFF),
    .TREP_CYC(TREP),
    .WAKE_DEF_CYC(400),
    .TON_MAX_CYC(64),
    .SYNC_LOST_CYC(2000)
  ) u_fvb_core (
    .clk(clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .zero_cross_pin(zero_cross_pin),
    .supply_wake_pin(supply_wake_pin),
    .supply_stop_pin(supply_stop_pin),
    .fb_valid(fb_valid),
    .fb_ua(fb_ua),
    .pos_clamp_current(pos_clamp_current),
    .neg_clamp_current(neg_clamp_current),
    .cfg_valid(cfg_valid),
    .cfg_strong_kohm(cfg_strong_kohm),
    .cfg_weak_kohm(cfg_weak_kohm),
    .line_tick(line_tick),
    .ripple_ok(ripple_ok),
    .gate_on(gate_on),
    .gate_reduced(gate_reduced),
    .pullup_on(pullup_on),
    .sleep(sleep)
  );

  fvb_winding_model u_fvb_winding_model (
    .clk(clk),
    .gate_on(gate_on),
    .ring_en(ring_en),
    .zero_cross_pin(zero_cross_pin)
  );

  // ==========================================
  // clock, line ticks and gate edge counter
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    gate_q <= gate_on;
    if (gate_on === 1'b1 && gate_q === 1'b0)
      rises <= rises + 1;
    lk <= (lk == 249) ? 0 : lk + 1;
    line_tick <= line_en && lk == 0;
  end

  // ==========================================
  // tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", s, exp, seen);
    end
  endtask

  task automatic hang();
    bad_count++;
    print_verdict();
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] wd);
    int n;
    n = 0;
    address <= a;
    read <= !w;
    write <= w;
    writedata <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    if (n >= 20)
      hang();
  endtask

  task automatic feed(input logic [9:0] f, input int settle);
    fb_ua <= f;
    fb_valid <= 1'b1;
    @(posedge clk);
    fb_valid <= 1'b0;
    repeat (settle) @(posedge clk);
  endtask

  task automatic cfg(input logic [7:0] s, input logic [7:0] w);
    cfg_strong_kohm <= s;
    cfg_weak_kohm <= w;
    cfg_valid <= 1'b1;
    @(posedge clk);
    cfg_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run_of(input logic lv, output int r);
    r = 0;
    while (sleep === lv && r < 3000)
    begin
      @(posedge clk);
      r++;
    end
    if (r >= 3000)
      hang();
  endtask

  task automatic off_time(output int o);
    int n;
    n = 0;
    while (gate_on !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    while (gate_on !== 1'b0 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    o = 0;
    while (gate_on !== 1'b1 && o < 500)
    begin
      @(posedge clk);
      o++;
    end
    if (n >= 500 || o >= 500)
      hang();
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {rst, read, write, fb_valid, cfg_valid, ring_en} = 6'h21;
    {ripple_ok, line_en} = 2'h0;
    {supply_wake_pin, supply_stop_pin} = 2'h0;
    {address, cfg_strong_kohm, cfg_weak_kohm} = 24'h0;
    {writedata, fb_ua} = 42'h0;
    pos_clamp_current = 10'h064;
    neg_clamp_current = 10'h064;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(8'h00, 1'b0, 32'h0);
    chk("ctrl", q, 32'h2);
    bus(8'h04, 1'b0, 32'h0);
    chk("pullup", q[5], 32'h1);
    bus(8'h1C, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    // too little resistance on the strong pull-up: no sensing
    cfg(8'h1A, 8'h50);
    bus(8'h00, 1'b1, 32'h1);
    r0 = rises;
    feed(10'h0D2, 300);
    bus(8'h04, 1'b0, 32'h0);
    chk("fb_en low", q[3], 32'h0);
    chk("no pulses", rises, r0);
    bus(8'h00, 1'b1, 32'h0);
    cfg(8'h1B, 8'h50);
    bus(8'h10, 1'b0, 32'h0);
    chk("gain", q, 32'h44);
    bus(8'h00, 1'b1, 32'h1);
    feed(10'h0D2, 300);
    bus(8'h04, 1'b0, 32'h0);
    chk("fb_en", q[3], 32'h1);
    chk("pulses", 32'(rises > r0), 32'h1);
    foreach (fbs[i])
    begin
      feed(fbs[i], 300);
      bus(8'h08, 1'b0, 32'h0);
      chk("valley", q, vls[i]);
    end
    // off-time: first valley, TOFF limit at valley 31, no ringing
    feed(10'h0D2, 300);
    off_time(t);
    chk("valley1", 32'(t <= 12), 32'h1);
    feed(10'h226, 300);
    off_time(t);
    chk("toff", 32'(t >= TOFF - 1 && t <= TOFF + 8), 32'h1);
    ring_en <= 1'b0;
    off_time(t);
    chk("trep", 32'(t >= TREP - 1 && t <= TREP + 3), 32'h1);
    ring_en <= 1'b1;
    // on-time saturation at max power, zero-cross extension, then saturation at min power
    feed(10'h064, 300);
    bus(8'h0C, 1'b0, 32'h0);
    t0 = q;
    feed(10'h0D2, 300);
    bus(8'h0C, 1'b0, 32'h0);
    chk("ton max", q, t0);
    neg_clamp_current <= 10'h050;
    repeat (300) @(posedge clk);
    bus(8'h0C, 1'b0, 32'h0);
    chk("ton at 80", q, t0);
    neg_clamp_current <= 10'h04F;
    repeat (300) @(posedge clk);
    bus(8'h0C, 1'b0, 32'h0);
    chk("ton ext", 32'(q > t0), 32'h1);
    neg_clamp_current <= 10'h064;
    feed(10'h262, 300);
    bus(8'h0C, 1'b0, 32'h0);
    t0 = q;
    feed(10'h2BC, 300);
    bus(8'h0C, 1'b0, 32'h0);
    chk("ton min", q, t0);
    // burst entry with default wake period
    bus(8'h00, 1'b1, 32'h3);
    feed(10'h244, 0);
    run_of(1'b0, t);
    bus(8'h04, 1'b0, 32'h0);
    chk("burst", q[2:0], 32'h7);
    feed(10'h258, 0);
    r0 = rises;
    run_of(1'b1, t);
    // sleep lags the gate by one edge: only the wake pulse is counted
    chk("asleep", rises, r0 + 1);
    chk("reduced", gate_reduced, 32'h1);
    run_of(1'b0, b);
    chk("window", 32'(b >= 57 && b <= 66), 32'h1);
    chk("burst pulses", 32'(rises > r0), 32'h1);
    run_of(1'b1, t);
    chk("wake", 32'(b + t >= 397 && b + t <= 403), 32'h1);
    run_of(1'b0, b);
    // a skipped wake stretches the cycle by one period
    d = 0;
    while (sleep === 1'b1 && d < 3000)
    begin
      fb_valid <= (d == 2 || d == 500);
      fb_ua <= (d < 500) ? 10'h26C : 10'h258;
      @(posedge clk);
      d++;
    end
    chk("skip", 32'(d >= 736 && d <= 744), 32'h1);
    run_of(1'b0, b);
    repeat (50) @(posedge clk);
    supply_wake_pin <= 1'b1;
    run_of(1'b1, t);
    chk("vcc wake", 32'(t <= 6), 32'h1);
    repeat (3) @(posedge clk);
    chk("pullup off", pullup_on, 32'h0);
    repeat (200) @(posedge clk);
    chk("vcc burst", sleep, 32'h0);
    supply_stop_pin <= 1'b1;
    run_of(1'b0, t);
    chk("vcc stop", 32'(t <= 6), 32'h1);
    repeat (3) @(posedge clk);
    chk("pullup on", pullup_on, 32'h1);
    supply_wake_pin <= 1'b0;
    feed(10'h12C, 0);
    supply_stop_pin <= 1'b0;
    run_of(1'b1, t);
    repeat (20) @(posedge clk);
    bus(8'h04, 1'b0, 32'h0);
    chk("burst left", q[2:0], 32'h0);
    // line sync needs visible ripple
    line_en <= 1'b1;
    repeat (1200) @(posedge clk);
    bus(8'h04, 1'b0, 32'h0);
    chk("no sync", q[4], 32'h0);
    ripple_ok <= 1'b1;
    repeat (1200) @(posedge clk);
    bus(8'h04, 1'b0, 32'h0);
    chk("sync", q[4], 32'h1);
    // synced burst entry: four wakes per 500-cycle line period
    feed(10'h258, 0);
    run_of(1'b0, t);
    run_of(1'b1, t);
    run_of(1'b0, b);
    run_of(1'b1, t);
    chk("line wake", 32'(b + t >= 122 && b + t <= 126), 32'h1);
    bus(8'h00, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    chk("stopped", gate_on, 32'h0);
    print_verdict();
  end
endmodule // fvb_core_tb
